// File: include/lhp_params.svh
`ifndef LHP_PARAMS_SVH
`define LHP_PARAMS_SVH

// ==================================================================
// Strap field positions
`define LHP_CNF_WIDTH     5
`define LHP_CNF_VAR_LSB   2
`define LHP_CNF_VAR_MSB   4

// ==================================================================
// Reset values
`define LHP_PIN_RST       33'h0_0000_0000
`define LHP_DATA_RST      8'h00
`define LHP_CNF_RST       3'h0

// ==================================================================
// Timing counts
`define LHP_SETTLE_CYCLES 2'h3

`endif

// File: include/lhp_pkg.sv
package lhp_pkg;

  // ================================================================
  // Host bus variant selected by the straps
  typedef enum logic [2:0] {
    LHP_VAR_GENERIC = 3'h0,
    LHP_VAR_ENABLE  = 3'h1,
    LHP_VAR_DSTROBE = 3'h2
  } lhp_variant_t;

  // ================================================================
  // Decoded bus operation
  typedef enum logic [1:0] {
    LHP_OP_NOP  = 2'h0,
    LHP_OP_READ = 2'h1,
    LHP_OP_DWR  = 2'h2,
    LHP_OP_CWR  = 2'h3
  } lhp_op_t;

  // ================================================================
  // Access state, Gray along idle to read and idle to write
  typedef enum logic [1:0] {
    LHP_ST_IDLE  = 2'h0,
    LHP_ST_READ  = 2'h1,
    LHP_ST_WRITE = 2'h2
  } lhp_state_t;

endpackage

// File: include/lhp_dec_if.sv
`timescale 1ns/1ps
interface lhp_dec_if;
  logic                  sel;
  logic [2:0]            variant;
  logic                  reg_sel;
  logic                  pin_a;
  logic                  pin_b;
  logic                  addr_strobe;
  lhp_pkg::lhp_op_t      op;

  modport dec  (input sel, variant, reg_sel, pin_a, pin_b, addr_strobe, output op);
  modport user (output sel, variant, reg_sel, pin_a, pin_b, addr_strobe, input op);
endinterface

// File: hdl/lhp_decoder.sv
`timescale 1ns/1ps
module lhp_decoder (
  // Decode request and result
  lhp_dec_if.dec bus
);

  // ================================================================
  // Strobe decode per bus variant; unlisted combinations stay idle
  always_comb begin
    bus.op = lhp_pkg::LHP_OP_NOP;
    if (bus.sel) begin
      case (bus.variant)
        lhp_pkg::LHP_VAR_GENERIC: begin
          // pin_a is the read strobe, pin_b the write strobe
          if (bus.reg_sel && !bus.pin_a && bus.pin_b) begin
            bus.op = lhp_pkg::LHP_OP_READ;
          end else if (bus.pin_a && !bus.pin_b) begin
            bus.op = bus.reg_sel ? lhp_pkg::LHP_OP_CWR
                                 : lhp_pkg::LHP_OP_DWR;
          end
        end
        lhp_pkg::LHP_VAR_ENABLE: begin
          // pin_a is the enable, pin_b the read/write line
          if (bus.pin_a) begin
            if (bus.pin_b && bus.reg_sel) begin
              bus.op = lhp_pkg::LHP_OP_READ;
            end else if (!bus.pin_b) begin
              bus.op = bus.reg_sel ? lhp_pkg::LHP_OP_CWR
                                   : lhp_pkg::LHP_OP_DWR;
            end
          end
        end
        lhp_pkg::LHP_VAR_DSTROBE: begin
          // pin_a is lower_data_strobe_n, pin_b the read/write line
          if (!bus.pin_a && bus.addr_strobe) begin
            if (bus.pin_b && bus.reg_sel) begin
              bus.op = lhp_pkg::LHP_OP_READ;
            end else if (!bus.pin_b) begin
              bus.op = bus.reg_sel ? lhp_pkg::LHP_OP_CWR
                                   : lhp_pkg::LHP_OP_DWR;
            end
          end
        end
        default: begin
          bus.op = lhp_pkg::LHP_OP_NOP;
        end
      endcase
    end
  end

endmodule

// File: hdl/lhp_host_port.sv
// How it works
// - Port samples straps, high address, register_select, data, strobes, addr_strobe, select.
// - Three strap bits choose generic, enable-strobed or data-strobe bus behaviour.
// - Generic: select+read reads; write strobe writes data (select low) or command.
// - Enable variant, enable high: read line+select reads; read line low: data or command write.
// - Data strobe low with addr_strobe high: read line+select reads; read line low: data or command write.
`timescale 1ns/1ps
`include "lhp_params.svh"
module lhp_host_port #(
  parameter int             DATA_W     = 8,
  parameter int             ADDR_HI_W  = 15,
  parameter logic [14:0]    ADDR_MATCH = 15'h0000,
  parameter logic [14:0]    ADDR_MASK  = 15'h0000
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Host bus pins
  input  wire logic [4:0]              bus_config_straps,
  input  wire logic [ADDR_HI_W-1:0]    addr_hi,
  input  wire logic                    register_select,
  input  wire logic [DATA_W-1:0]       data_in,
  output logic      [DATA_W-1:0]       data_out,
  output logic                         data_oe_n,
  input  wire logic                    rd_strobe_n,
  input  wire logic                    wr_strobe_n,
  input  wire logic                    addr_strobe,
  input  wire logic                    chip_select_n,
  // Controller core side
  input  wire logic [DATA_W-1:0]       rd_data,
  output logic                         rd_req,
  output logic                         data_wr,
  output logic                         cmd_wr,
  output logic      [DATA_W-1:0]       wr_data,
  output logic      [2:0]              bus_variant,
  output logic                         port_ready
);

  localparam int PIN_W = 5 + ADDR_HI_W + 1 + DATA_W + 4;

  // ================================================================
  // Elaboration checks
  if (DATA_W != 8) begin : g_bad_data
    $error("data bus width must be 8");
  end
  if (ADDR_HI_W != 15) begin : g_bad_addr
    $error("high address width must be 15");
  end

  // ================================================================
  // Pin synchronisers: every pin passes two flip-flops
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;

  // Gather the pins into one vector
  assign pins = {bus_config_straps, addr_hi, register_select, data_in,
                 rd_strobe_n, wr_strobe_n, addr_strobe, chip_select_n};

  // Two-stage synchroniser; only sync2_q is read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= PIN_W'(`LHP_PIN_RST);
      sync2_q <= PIN_W'(`LHP_PIN_RST);
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // Unpack the synchronised pins
  logic [4:0]           s_straps;
  logic [ADDR_HI_W-1:0] s_addr;
  logic                 s_rs;
  logic [DATA_W-1:0]    s_data;
  logic                 s_pin_a;
  logic                 s_pin_b;
  logic                 s_as;
  logic                 s_cs_n;
  assign {s_straps, s_addr, s_rs, s_data, s_pin_a, s_pin_b, s_as, s_cs_n} = sync2_q;

  // ================================================================
  // Strap capture after reset release
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic [2:0] variant_q;
  logic [2:0] variant_d;
  logic       ready_q;
  logic       ready_d;

  // Wait for the synchroniser to fill, then latch the variant once
  always_comb begin
    settle_d  = settle_q;
    variant_d = variant_q;
    ready_d   = ready_q;
    if (!ready_q) begin
      if (settle_q == `LHP_SETTLE_CYCLES) begin
        variant_d = s_straps[`LHP_CNF_VAR_MSB:`LHP_CNF_VAR_LSB];
        ready_d   = 1'b1;
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
  end

  // Register strap capture state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q  <= 2'h0;
      variant_q <= `LHP_CNF_RST;
      ready_q   <= 1'b0;
    end else begin
      settle_q  <= settle_d;
      variant_q <= variant_d;
      ready_q   <= ready_d;
    end
  end

  assign bus_variant = variant_q;
  assign port_ready  = ready_q;

  // ================================================================
  // Operation decode
  lhp_dec_if dec_bus ();
  lhp_pkg::lhp_op_t op;

  // Chip select and optional high address match gate the decode
  assign dec_bus.sel         = ready_q && !s_cs_n &&
                               ((s_addr & ADDR_MASK) == (ADDR_MATCH & ADDR_MASK));
  assign dec_bus.variant     = variant_q;
  assign dec_bus.reg_sel     = s_rs;
  assign dec_bus.pin_a       = s_pin_a;
  assign dec_bus.pin_b       = s_pin_b;
  assign dec_bus.addr_strobe = s_as;
  assign op                  = dec_bus.op;

  lhp_decoder u_dec (
    .bus (dec_bus.dec)
  );

  // ================================================================
  // Access sequencer
  lhp_pkg::lhp_state_t state_q;
  lhp_pkg::lhp_state_t state_d;
  lhp_pkg::lhp_op_t    wop_q;
  lhp_pkg::lhp_op_t    wop_d;
  logic [DATA_W-1:0]   wbuf_q;
  logic [DATA_W-1:0]   wbuf_d;
  logic [DATA_W-1:0]   rdat_q;
  logic [DATA_W-1:0]   rdat_d;
  logic                rd_req_d;
  logic                rd_req_q;
  logic                dwr_d;
  logic                dwr_q;
  logic                cwr_d;
  logic                cwr_q;

  // Read starts at strobe entry; writes commit data at strobe end
  always_comb begin
    state_d  = state_q;
    wop_d    = wop_q;
    wbuf_d   = wbuf_q;
    rdat_d   = rdat_q;
    rd_req_d = 1'b0;
    dwr_d    = 1'b0;
    cwr_d    = 1'b0;
    case (state_q)
      lhp_pkg::LHP_ST_IDLE: begin
        if (op == lhp_pkg::LHP_OP_READ) begin
          state_d  = lhp_pkg::LHP_ST_READ;
          rd_req_d = 1'b1;
          rdat_d   = rd_data;
        end else if (op == lhp_pkg::LHP_OP_DWR || op == lhp_pkg::LHP_OP_CWR) begin
          state_d = lhp_pkg::LHP_ST_WRITE;
          wop_d   = op;
          wbuf_d  = s_data;
        end
      end
      lhp_pkg::LHP_ST_READ: begin
        rdat_d = rd_data;
        if (op != lhp_pkg::LHP_OP_READ) begin
          state_d = lhp_pkg::LHP_ST_IDLE;
        end
      end
      lhp_pkg::LHP_ST_WRITE: begin
        if (op == wop_q) begin
          wbuf_d = s_data;
        end else begin
          state_d = lhp_pkg::LHP_ST_IDLE;
          dwr_d   = (wop_q == lhp_pkg::LHP_OP_DWR);
          cwr_d   = (wop_q == lhp_pkg::LHP_OP_CWR);
        end
      end
      default: begin
        state_d = lhp_pkg::LHP_ST_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= lhp_pkg::LHP_ST_IDLE;
      wop_q    <= lhp_pkg::LHP_OP_NOP;
      wbuf_q   <= `LHP_DATA_RST;
      rdat_q   <= `LHP_DATA_RST;
      rd_req_q <= 1'b0;
      dwr_q    <= 1'b0;
      cwr_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      wop_q    <= wop_d;
      wbuf_q   <= wbuf_d;
      rdat_q   <= rdat_d;
      rd_req_q <= rd_req_d;
      dwr_q    <= dwr_d;
      cwr_q    <= cwr_d;
    end
  end

  // Outputs
  assign rd_req    = rd_req_q;
  assign data_wr   = dwr_q;
  assign cmd_wr    = cwr_q;
  assign wr_data   = wbuf_q;
  assign data_out  = rdat_q;
  assign data_oe_n = (state_q != lhp_pkg::LHP_ST_READ);

  // ================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_held;
    state_q == lhp_pkg::LHP_ST_WRITE && op == wop_q;
  endsequence

  sequence s_write_end;
    state_q == lhp_pkg::LHP_ST_WRITE && op != wop_q;
  endsequence

  a_variant_stable: assert property (ready_q |=> $stable(variant_q))
    else $error("bus variant changed after capture");

  a_ready_delay: assert property ($rose(ready_q) |-> settle_q == `LHP_SETTLE_CYCLES)
    else $error("straps captured too early");

  a_no_op_idle: assert property (!ready_q |-> op == lhp_pkg::LHP_OP_NOP)
    else $error("decode active before straps captured");

  a_nop_no_pulse: assert property (
    (state_q == lhp_pkg::LHP_ST_IDLE && op == lhp_pkg::LHP_OP_NOP)
      |=> !rd_req_q && !dwr_q && !cwr_q && state_q == lhp_pkg::LHP_ST_IDLE)
    else $error("idle bus produced an access");

  a_generic_read: assert property (
    (ready_q && variant_q == 3'h0 && !s_cs_n && s_rs && !s_pin_a && s_pin_b
      && ADDR_MASK == 15'h0000) |-> op == lhp_pkg::LHP_OP_READ)
    else $error("generic read not decoded");

  a_enable_cmd: assert property (
    (ready_q && variant_q == 3'h1 && !s_cs_n && s_rs && s_pin_a && !s_pin_b
      && ADDR_MASK == 15'h0000) |-> op == lhp_pkg::LHP_OP_CWR)
    else $error("enable variant command write not decoded");

  a_dstrobe_data: assert property (
    (ready_q && variant_q == 3'h2 && !s_cs_n && !s_rs && !s_pin_a && !s_pin_b && s_as
      && ADDR_MASK == 15'h0000) |-> op == lhp_pkg::LHP_OP_DWR)
    else $error("data strobe variant data write not decoded");

  a_write_commit: assert property (
    s_write_held ##1 s_write_end |=> (dwr_q || cwr_q) && $past(wbuf_q) == wbuf_q)
    else $error("write not committed at strobe end");

  a_read_oe: assert property (
    $rose(rd_req_q) |-> !data_oe_n ##1 !rd_req_q)
    else $error("read did not drive the data bus");

  a_rs_low_read: assert property (
    (ready_q && !s_rs && variant_q != 3'h3) |-> op != lhp_pkg::LHP_OP_READ)
    else $error("read decoded with register select low");

endmodule

// File: verification/lhp_host_model.sv
`timescale 1ns/1ps
// ==========
// Host bus master standing in for the microprocessor
module lhp_host_model (
  // Clock
  input  wire logic       clk,
  // Pins toward the port
  output logic [14:0]     addr_hi,
  output logic            register_select,
  output logic [7:0]      data_in,
  output logic            rd_strobe_n,
  output logic            wr_strobe_n,
  output logic            addr_strobe,
  output logic            chip_select_n,
  // Port drive back
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  int         cyc = 0;
  int         on_cyc = 0;
  int         off_cyc = 0;
  logic       host_oe = 1'b0;
  logic [7:0] host_d = 8'h00;
  logic [7:0] last_d = 8'h00;
  logic       as_on = 1'b1;

  // Cycle count for latency checks
  always @(posedge clk) cyc <= cyc + 1;

  // Bus level: port, host, else inverse of the last driven byte
  always @(posedge clk) if (host_oe || !data_oe_n) last_d <= data_in;
  assign data_in = !data_oe_n ? data_out : host_oe ? host_d : ~last_d;

  // Straps stay fixed; strobes rest at the variant's idle level
  task automatic set_idle(input logic ai, input logic bi);
    rd_strobe_n     = ai;
    wr_strobe_n     = bi;
    chip_select_n   = 1'b1;
    addr_strobe     = 1'b0;
    register_select = 1'b0;
    addr_hi         = 15'h2A5C;
  endtask

  // One access: strobes held 3 cycles, then 6 idle cycles
  task automatic access(input logic cs_n, input logic rs, input logic a, input logic b,
                        input logic [7:0] d, input logic ai, input logic bi);
    @(posedge clk);
    #1;
    chip_select_n   = cs_n;
    register_select = rs;
    rd_strobe_n     = a;
    wr_strobe_n     = b;
    addr_strobe     = as_on; // Qualifier, normally high
    host_d          = d;
    host_oe         = ~b;
    on_cyc          = cyc;
    repeat (3) @(posedge clk);
    #1;
    rd_strobe_n     = ai;
    wr_strobe_n     = bi;
    off_cyc         = cyc;
    @(posedge clk);
    #1;
    chip_select_n   = 1'b1;
    addr_strobe     = 1'b0;
    host_oe         = 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask
endmodule

// File: verification/lcd_ctrl_host_bus_port_bench.sv
`timescale 1ns/1ps
// ==========
// Bench for the host bus port
module lcd_ctrl_host_bus_port_bench;
  logic       clk;
  logic       rst_n;
  logic [4:0] straps;
  logic [14:0] addr_hi;
  logic       rs;
  logic [7:0] data_in;
  logic       rd_n;
  logic       wr_n;
  logic       as;
  logic       cs_n;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic [7:0] rd_data;
  logic       rd_req;
  logic       data_wr;
  logic       cmd_wr;
  logic [7:0] wr_data;
  logic [2:0] bus_variant;
  logic       port_ready;
  logic [7:0] last_out;
  int         mismatches = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n_rd = 0;
  int         n_dw = 0;
  int         n_cw = 0;
  int         n_oe = 0;
  int         rd_at = 0;
  int         wr_at = 0;

  lhp_host_port DUT (.clk(clk), .rst_n(rst_n), .bus_config_straps(straps),
    .addr_hi(addr_hi), .register_select(rs), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .addr_strobe(as),
    .chip_select_n(cs_n), .rd_data(rd_data), .rd_req(rd_req), .data_wr(data_wr),
    .cmd_wr(cmd_wr), .wr_data(wr_data), .bus_variant(bus_variant),
    .port_ready(port_ready));

  lhp_host_model host (.clk(clk), .addr_hi(addr_hi), .register_select(rs),
    .data_in(data_in), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .addr_strobe(as),
    .chip_select_n(cs_n), .data_out(data_out), .data_oe_n(data_oe_n));

  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  // Settled pulse and drive monitor
  always @(negedge clk) begin
    if (rd_req === 1'b1) begin
      n_rd++;
      rd_at = host.cyc;
    end
    if (data_wr === 1'b1 || cmd_wr === 1'b1) wr_at = host.cyc;
    if (data_wr === 1'b1) n_dw++;
    if (cmd_wr === 1'b1) n_cw++;
    if (data_oe_n === 1'b0) begin
      n_oe++;
      last_out = data_out;
    end
  end

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic reset_port(input logic [2:0] v, input logic ai, input logic bi);
    int n;
    rst_n = 1'b0;
    straps = {v, 2'h0};
    host.set_idle(ai, bi);
    repeat (8) @(posedge clk);
    #1;
    check(data_oe_n === 1'b1 && port_ready === 1'b0, "reset state");
    rst_n = 1'b1;
    n = 0;
    while (port_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1;
    check(port_ready === 1'b1, "port not ready");
    check(v > 3'h2 || bus_variant === v, "variant not captured");
    repeat (3) @(posedge clk);
  endtask

  task automatic wr_op(input logic rs_v, input logic a, input logic b, input logic ai,
                       input logic bi, input logic [7:0] d, input logic is_cmd);
    int dw0 = n_dw;
    int cw0 = n_cw;
    int oe0 = n_oe;
    host.access(1'b0, rs_v, a, b, d, ai, bi);
    check(n_dw - dw0 == int'(!is_cmd), "data pulse count");
    check(n_cw - cw0 == int'(is_cmd), "command pulse count");
    check(wr_data === d, "write byte");
    check(wr_at - host.off_cyc == 3, "write latency");
    check(n_oe == oe0, "port drove bus on write");
  endtask

  task automatic rd_op(input logic a, input logic b, input logic ai, input logic bi,
                       input logic [7:0] d);
    int rd0 = n_rd;
    rd_data = d;
    host.access(1'b0, 1'b1, a, b, 8'h00, ai, bi);
    check(n_rd - rd0 == 1, "read count");
    check(rd_at - host.on_cyc == 3, "read latency");
    check(last_out === d, "read byte");
    check(data_oe_n === 1'b1, "bus not released");
  endtask

  task automatic nop_op(input logic cs, input logic rs_v, input logic a, input logic b,
                        input logic ai, input logic bi);
    int s0 = n_rd + n_dw + n_cw + n_oe;
    logic [7:0] w0 = wr_data;
    host.access(cs, rs_v, a, b, 8'h69, ai, bi);
    check(n_rd + n_dw + n_cw + n_oe == s0 && wr_data === w0, "refused acted");
  endtask

  task automatic test_generic();
    reset_port(3'h0, 1'b1, 1'b1);
    wr_op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h3C, 1'b0);
    wr_op(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'hC3, 1'b1);
    rd_op(1'b0, 1'b1, 1'b1, 1'b1, 8'h96);
    nop_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    nop_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    nop_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic test_enable();
    reset_port(3'h1, 1'b0, 1'b1);
    wr_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h81, 1'b0);
    wr_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h7E, 1'b1);
    rd_op(1'b1, 1'b1, 1'b0, 1'b1, 8'h24);
    nop_op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask

  task automatic test_dstrobe();
    reset_port(3'h2, 1'b1, 1'b1);
    wr_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h55, 1'b0);
    wr_op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'hAA, 1'b1);
    rd_op(1'b0, 1'b1, 1'b1, 1'b1, 8'hE7);
    nop_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    // Data write with the address strobe low must be ignored
    host.as_on = 1'b0;
    nop_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    host.as_on = 1'b1;
  endtask

  task automatic test_unknown();
    reset_port(3'h3, 1'b1, 1'b1);
    nop_op(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    nop_op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic end_sim();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    straps = 5'h00;
    rd_data = 8'h00;
    host.set_idle(1'b1, 1'b1);
    test_generic();
    test_enable();
    test_dstrobe();
    test_unknown();
    end_sim();
  end
endmodule
